/* logic/pcl_pkg.sv */
// constants shared by the parallel configuration loader
package pcl_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] PCL_CTRL_OFS   = 8'h00;
  localparam logic [7:0] PCL_LEN_OFS    = 8'h04;
  localparam logic [7:0] PCL_STAT_OFS   = 8'h08;
  localparam logic [7:0] PCL_WORD_OFS   = 8'h0c;
  localparam logic [7:0] PCL_CNT_OFS    = 8'h10;
  localparam logic [7:0] PCL_UOUT_OFS   = 8'h14;
  localparam logic [7:0] PCL_UOE_OFS    = 8'h18;

  // ctrl field positions
  localparam int PCL_CTRL_WID_LSB  = 0;
  localparam int PCL_CTRL_DECOMP   = 2;
  localparam int PCL_CTRL_DECRYPT  = 3;
  localparam int PCL_CTRL_INITEN   = 4;
  localparam int PCL_CTRL_USERCLK  = 5;

  // reset values
  localparam logic [5:0]  PCL_CTRL_RST = 6'h00;
  localparam logic [31:0] PCL_LEN_RST  = 32'h0000_0001;

  // scheme width codes
  localparam logic [1:0] PCL_W8  = 2'h0;
  localparam logic [1:0] PCL_W16 = 2'h1;
  localparam logic [1:0] PCL_W32 = 2'h2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int PCL_CLK_NS          = 25;
  localparam int PCL_REQ_LOW_MAX_NS  = 600;
  localparam int PCL_STATUS_MIN_US   = 268;
  localparam int PCL_STATUS_MAX_US   = 1506;
  localparam int PCL_INIT_MIN_US     = 175;
  localparam int PCL_INIT_MAX_US     = 437;
  localparam int PCL_CCLK_MIN_NS     = 10;
  localparam int PCL_USER_EN_PERIODS = 4;
  localparam int PCL_USER_INIT_EDGES = 8576;
  localparam int PCL_DONE_FALLS      = 2;

  localparam int PCL_STATUS_CYC =
    (PCL_STATUS_MIN_US * 1000 + PCL_CLK_NS - 1) / PCL_CLK_NS;
  localparam int PCL_INIT_CYC =
    (PCL_INIT_MIN_US * 1000 + PCL_CLK_NS - 1) / PCL_CLK_NS;
  localparam int PCL_USER_EN_CYC =
    (PCL_USER_EN_PERIODS * PCL_CCLK_MIN_NS + PCL_CLK_NS - 1) / PCL_CLK_NS;

  typedef enum logic [2:0] {
    PCL_ST_POR, PCL_ST_RESET, PCL_ST_WAIT, PCL_ST_LOAD,
    PCL_ST_DONE, PCL_ST_INITDLY, PCL_ST_INIT, PCL_ST_USER
  } pcl_state_e;

endpackage

/* logic/pcl_sync.sv */
// two-flop synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module pcl_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // async input and synced result
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta;
  logic [W-1:0] prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
      prev <= '0;
    end else begin
      meta <= d;
      q    <= meta;
      prev <= q;
    end
  end

  // edges come from the second and third flops only
  assign rise = q & ~prev;
  assign fall = ~q & prev;
endmodule
`default_nettype wire

/* logic/pcl_loader.sv */
// parallel configuration load port, device side, with apb registers
//
// Behaviour
// R1: 8-bit ratio 1, 2 when decompressing
// R2: 16-bit ratio 1, 2 decrypting, 4 decompressing
// R3: 32-bit ratio 1, 4 decrypting, 8 decompressing
// R4: host clocks ratio times word rate
// R5: host clocks ratio-1 more after last word
// R6: 16-bit uses lines 15..0, 8-bit 7..0
// R7: words captured on config clock rising edge
// R8: user mode lines high; request low reconfigures
// R9: status held low for power-on delay
// R10: done low from power-up through load
// R11: done released only after complete image
// R12: host gives two falling edges after done
// R13: config clock ignored after configuration
// R14: init-complete output low until initialisation ends
// R15: data lines become user pins afterwards
// R16: done and status low within 600 ns
// R17: host holds request low two microseconds
// R18: status low 268 to 1506 microseconds
// R19: host waits before first clock edge
// R20: host clock limited to 125/100 MHz
// R21: internal oscillator init 175..437 microseconds
// R22: user clock init after 4 periods, 8576 cycles
// R23: host may pause clock low, data first
// R24: host holds each word ratio edges
// R25: status low during load means restart
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pcl_loader
  import pcl_pkg::*;
#(
  parameter int POR_CYC    = PCL_STATUS_CYC,
  parameter int STATUS_CYC = PCL_STATUS_CYC,
  parameter int INIT_CYC   = PCL_INIT_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // configuration pins
  input  wire logic        config_request_n,
  input  wire logic        config_clock,
  input  wire logic        user_init_clock,
  input  wire logic [31:0] data_in,
  output logic      [31:0] data_out,
  output logic      [31:0] data_oe,
  output logic             status_out,
  output logic             status_oe,
  output logic             done_out,
  output logic             done_oe,
  output logic             init_done_out,
  output logic             init_done_oe
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic        req_q;
  logic        cclk_rise;
  logic        cclk_fall;
  logic        uclk_rise;
  logic [31:0] data_q;

  pcl_sync #(.W(1)) u_req (.pclk(pclk), .presetn(presetn),
    .d(config_request_n), .q(req_q), .rise(), .fall());
  pcl_sync #(.W(1)) u_cclk (.pclk(pclk), .presetn(presetn),
    .d(config_clock), .q(), .rise(cclk_rise), .fall(cclk_fall));
  pcl_sync #(.W(1)) u_uclk (.pclk(pclk), .presetn(presetn),
    .d(user_init_clock), .q(), .rise(uclk_rise), .fall());
  // data pins delayed like the clock so a word lines up with its edge
  pcl_sync #(.W(32)) u_data (.pclk(pclk), .presetn(presetn),
    .d(data_in), .q(data_q), .rise(), .fall());

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [5:0]  ctrl;
  logic [31:0] img_len;
  logic [31:0] user_out;
  logic [31:0] user_oe;
  logic [5:0]  next_ctrl;
  logic [31:0] next_img_len;
  logic [31:0] next_user_out;
  logic [31:0] next_user_oe;
  logic        wr_en;
  logic        mapped;

  pcl_state_e  state;
  pcl_state_e  next_state;
  logic [16:0] cnt;
  logic [16:0] next_cnt;
  logic [2:0]  phase;
  logic [2:0]  next_phase;
  logic [31:0] words;
  logic [31:0] next_words;
  logic [31:0] word;
  logic [31:0] next_word;
  logic [1:0]  falls;
  logic [1:0]  next_falls;
  logic [3:0]  ratio;
  logic [31:0] lane_mask;

  assign wr_en  = psel && penable && pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == PCL_CTRL_OFS) || (paddr == PCL_LEN_OFS) ||
                  (paddr == PCL_STAT_OFS) || (paddr == PCL_WORD_OFS) ||
                  (paddr == PCL_CNT_OFS)  || (paddr == PCL_UOUT_OFS) ||
                  (paddr == PCL_UOE_OFS);
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    next_ctrl     = ctrl;
    next_img_len  = img_len;
    next_user_out = user_out;
    next_user_oe  = user_oe;
    if (wr_en) begin
      case (paddr)
        PCL_CTRL_OFS: next_ctrl     = pwdata[5:0];
        PCL_LEN_OFS:  next_img_len  = pwdata;
        PCL_UOUT_OFS: next_user_out = pwdata;
        PCL_UOE_OFS:  next_user_oe  = pwdata;
        default:      next_ctrl     = ctrl;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= PCL_CTRL_RST;
      img_len  <= PCL_LEN_RST;
      user_out <= '0;
      user_oe  <= '0;
    end else begin
      ctrl     <= next_ctrl;
      img_len  <= next_img_len;
      user_out <= next_user_out;
      user_oe  <= next_user_oe;
    end
  end

  // read data comes straight from state; reads have no side effect
  always_comb begin
    case (paddr)
      PCL_CTRL_OFS: prdata = {26'h0, ctrl};
      PCL_LEN_OFS:  prdata = img_len;
      PCL_STAT_OFS: prdata = {24'h0, falls, phase, state};
      PCL_WORD_OFS: prdata = word;
      PCL_CNT_OFS:  prdata = words;
      PCL_UOUT_OFS: prdata = user_out;
      PCL_UOE_OFS:  prdata = user_oe;
      default:      prdata = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // ratio and lane selection
  // ---------------------------------------------------------------
  always_comb begin
    case (ctrl[PCL_CTRL_WID_LSB +: 2])
      PCL_W8: begin
        ratio     = ctrl[PCL_CTRL_DECOMP] ? 4'h2 : 4'h1; // R1
        lane_mask = 32'h0000_00ff; // R6
      end
      PCL_W16: begin
        ratio     = ctrl[PCL_CTRL_DECOMP]  ? 4'h4 : // R2
                    ctrl[PCL_CTRL_DECRYPT] ? 4'h2 : 4'h1;
        lane_mask = 32'h0000_ffff; // R6
      end
      default: begin
        ratio     = ctrl[PCL_CTRL_DECOMP]  ? 4'h8 : // R3
                    ctrl[PCL_CTRL_DECRYPT] ? 4'h4 : 4'h1;
        lane_mask = 32'hffff_ffff; // R6
      end
    endcase
  end

  // ---------------------------------------------------------------
  // load sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_phase = phase;
    next_words = words;
    next_word  = word;
    next_falls = falls;
    case (state)
      PCL_ST_POR: begin
        if (cnt == 17'h0) begin
          next_state = req_q ? PCL_ST_WAIT : PCL_ST_RESET; // R9
        end else begin
          next_cnt = cnt - 17'h1;
        end
      end
      PCL_ST_RESET: begin
        if (req_q) begin
          next_state = PCL_ST_WAIT;
          next_cnt   = STATUS_CYC[16:0]; // R18
        end
      end
      PCL_ST_WAIT: begin
        if (cnt == 17'h0) begin
          next_state = PCL_ST_LOAD; // R18
          next_phase = 3'h0;
          next_words = 32'h0;
        end else begin
          next_cnt = cnt - 17'h1;
        end
      end
      PCL_ST_LOAD: begin
        if (cclk_rise) begin // R7
          if (phase == 3'h0) begin
            next_word = data_q & lane_mask; // R6
          end
          // spare edges go to decrypt and inflate
          if (phase == 3'(ratio - 4'h1)) begin // R4
            next_phase = 3'h0;
            next_words = words + 32'h1;
            if (words + 32'h1 == img_len) begin
              next_state = PCL_ST_DONE; // R11
              next_falls = 2'h0;
            end
          end else begin
            next_phase = phase + 3'h1;
          end
        end
      end
      PCL_ST_DONE: begin
        if (cclk_fall) begin
          next_falls = falls + 2'h1;
          if (falls == 2'(PCL_DONE_FALLS - 1)) begin // R12
            if (ctrl[PCL_CTRL_USERCLK]) begin
              next_state = PCL_ST_INITDLY;
              next_cnt   = 17'(PCL_USER_EN_CYC - 1); // R22
            end else begin
              next_state = PCL_ST_INIT;
              next_cnt   = 17'(INIT_CYC - 1); // R21
            end
          end
        end
      end
      PCL_ST_INITDLY: begin
        if (cnt == 17'h0) begin
          next_state = PCL_ST_INIT;
          next_cnt   = 17'(PCL_USER_INIT_EDGES - 1); // R22
        end else begin
          next_cnt = cnt - 17'h1;
        end
      end
      PCL_ST_INIT: begin
        if (!ctrl[PCL_CTRL_USERCLK] || uclk_rise) begin
          if (cnt == 17'h0) begin
            next_state = PCL_ST_USER;
          end else begin
            next_cnt = cnt - 17'h1;
          end
        end
      end
      PCL_ST_USER: begin
        next_state = PCL_ST_USER; // R13
      end
      default: begin
        next_state = PCL_ST_RESET;
      end
    endcase
    // a low request restarts from any state but power-on
    if (!req_q && state != PCL_ST_POR) begin
      next_state = PCL_ST_RESET; // R8
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PCL_ST_POR;
      cnt   <= 17'(POR_CYC);
      phase <= 3'h0;
      words <= 32'h0;
      word  <= 32'h0;
      falls <= 2'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      phase <= next_phase;
      words <= next_words;
      word  <= next_word;
      falls <= next_falls;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_oe    <= 1'b1;
      done_oe      <= 1'b1;
      init_done_oe <= 1'b0;
      data_out     <= 32'h0;
      data_oe      <= 32'h0;
    end else begin
      status_oe    <= next_state == PCL_ST_POR || next_state == PCL_ST_RESET
                      || next_state == PCL_ST_WAIT; // R16
      done_oe      <= next_state == PCL_ST_POR || next_state == PCL_ST_RESET
                      || next_state == PCL_ST_WAIT
                      || next_state == PCL_ST_LOAD; // R10
      init_done_oe <= ctrl[PCL_CTRL_INITEN] && next_state != PCL_ST_USER
                      && next_state != PCL_ST_POR; // R14
      data_out     <= next_state == PCL_ST_USER ? user_out : 32'h0; // R15
      data_oe      <= next_state == PCL_ST_USER ? user_oe : 32'h0;
    end
  end

  // open-drain pins only ever pull low
  assign status_out    = 1'b0;
  assign done_out      = 1'b0;
  assign init_done_out = 1'b0;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_req_low;
    !req_q && state != PCL_ST_POR;
  endsequence
  sequence s_pins_low;
    status_oe && done_oe;
  endsequence

  property p_req_low;
    s_req_low |=> s_pins_low;
  endproperty
  a_req_low: assert property (p_req_low) else $error("pins not low"); // R16

  property p_por;
    state == PCL_ST_POR |=> status_oe;
  endproperty
  a_por: assert property (p_por) else $error("status released in por"); // R9

  property p_done_load;
    state == PCL_ST_LOAD |-> done_oe;
  endproperty
  a_done_load: assert property (p_done_load) else $error("done high"); // R10

  property p_done_rel;
    $fell(done_oe) |-> words == img_len;
  endproperty
  a_done_rel: assert property (p_done_rel) else $error("early done"); // R11

  property p_status_rel;
    $fell(status_oe) |-> $past(state) == PCL_ST_WAIT && $past(cnt) == 17'h0;
  endproperty
  a_status_rel: assert property (p_status_rel) else $error("status"); // R18

  property p_capture;
    word != $past(word) |-> $past(cclk_rise) || $past(!req_q);
  endproperty
  a_capture: assert property (p_capture) else $error("stray capture"); // R7

  property p_ratio16;
    ctrl[1:0] == PCL_W16 && ctrl[PCL_CTRL_DECOMP] |-> ratio == 4'h4;
  endproperty
  a_ratio16: assert property (p_ratio16) else $error("ratio x16"); // R2

  property p_ratio32;
    ctrl[1:0] == PCL_W32 && !ctrl[PCL_CTRL_DECOMP]
      && ctrl[PCL_CTRL_DECRYPT] |-> ratio == 4'h4;
  endproperty
  a_ratio32: assert property (p_ratio32) else $error("ratio x32"); // R3

  property p_user_hold;
    state == PCL_ST_USER && req_q |=> state == PCL_ST_USER;
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("left user"); // R13

  property p_user_pins;
    data_oe != 32'h0 |-> $past(state) == PCL_ST_USER || state == PCL_ST_USER;
  endproperty
  a_user_pins: assert property (p_user_pins) else $error("pins early"); // R15

  property p_init_out;
    init_done_oe |-> ctrl[PCL_CTRL_INITEN] || $past(ctrl[PCL_CTRL_INITEN]);
  endproperty
  a_init_out: assert property (p_init_out) else $error("init pin"); // R14

endmodule
`default_nettype wire

/* verification/pcl_host.sv */
// configuration host model that drives the parallel load pins
`timescale 1ns/1ps
`default_nettype none
module pcl_host (
  // configuration pins toward the device
  output logic        config_request_n,
  output logic        config_clock,
  output logic        user_init_clock,
  output logic [31:0] data_in
);
  initial begin
    config_request_n = 1'b1;
    config_clock     = 1'b0; // parked low, never floating
    user_init_clock  = 1'b0;
    data_in          = 32'h0;
  end

  // free user clock, 100 ns period keeps the long init count short
  always #50 user_init_clock = ~user_init_clock;

  // ---------------------------------------------------------------
  // host operations
  // ---------------------------------------------------------------
  task automatic pulse_request();
    #7 config_request_n = 1'b0;
    #4000 config_request_n = 1'b1; // low for 4 us
  endtask

  // one word held across ratio rises; the last word gets no r-1 extra rises
  task automatic send_word(input logic [31:0] w, input int r);
    #7 data_in = w; // valid before the first rise
    repeat (r) begin
      #100 config_clock = 1'b1; // 200 ns period, below limit
      #100 config_clock = 1'b0;
    end
    data_in = ~w; // word no longer held after its edges
  endtask

  task automatic clock_falls(input int k);
    #7;
    repeat (k) begin
      #100 config_clock = 1'b1; // extra falls for initialisation
      #100 config_clock = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* verification/test_parallel_config_loader.sv */
// self-checking bench for the parallel configuration loader
`timescale 1ns/1ps
`default_nettype none
module test_parallel_config_loader;
  import pcl_pkg::*;
  localparam int SHORT = 20;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, data_out, data_oe, data_in, rd, w;
  logic        pready, pslverr, status_out, status_oe, done_out;
  logic        done_oe, init_done_out, init_done_oe, se;
  logic        config_request_n, config_clock, user_init_clock;
  int          err_total   = 0;
  int          check_count = 0;
  int          n;
  logic [31:0] exp_q[$];

  always #12.5 pclk = ~pclk;

  pcl_loader #(.POR_CYC(SHORT), .STATUS_CYC(SHORT), .INIT_CYC(SHORT)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_request_n(config_request_n), .config_clock(config_clock),
    .user_init_clock(user_init_clock), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .status_out(status_out),
    .status_oe(status_oe), .done_out(done_out), .done_oe(done_oe),
    .init_done_out(init_done_out), .init_done_oe(init_done_oe));

  pcl_host host (
    .config_request_n(config_request_n), .config_clock(config_clock),
    .user_init_clock(user_init_clock), .data_in(data_in));

  // ---------------------------------------------------------------
  // reference model and helpers
  // ---------------------------------------------------------------
  function automatic int ratio_of(logic [1:0] wd, logic dc, logic dy);
    if (dc) return (wd == PCL_W8) ? 2 : (wd == PCL_W16) ? 4 : 8;
    if (dy) return (wd == PCL_W8) ? 1 : (wd == PCL_W16) ? 2 : 4;
    return 1;
  endfunction

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  // one apb transfer; waits for pready, takes data at that edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      err_total++;
      $display("ERROR pready expected 1 seen %b", pready);
    end
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_status(output int cnt);
    cnt = 0;
    while (status_oe !== 1'b0 && cnt < 2000) begin
      @(posedge pclk);
      cnt++;
    end
  endtask

  task automatic do_load(input logic [5:0] ctl, input int len);
    int          r;
    logic [31:0] m;
    r = ratio_of(ctl[1:0], ctl[2], ctl[3]);
    m = (ctl[1:0] == PCL_W8) ? 32'h0000_00ff :
        (ctl[1:0] == PCL_W16) ? 32'h0000_ffff : 32'hffff_ffff;
    apb(1'b1, PCL_CTRL_OFS, {26'h0, ctl});
    apb(1'b1, PCL_LEN_OFS, 32'(len));
    fork
      host.pulse_request();
      begin
        repeat (24) @(posedge pclk);
        check("status_oe", 32'h1, {31'h0, status_oe});
        check("done_oe", 32'h1, {31'h0, done_oe});
      end
    join
    wait_status(n);
    check("status span", 32'h1, {31'h0, n >= SHORT && n <= SHORT + 10});
    repeat (80) @(posedge pclk);
    exp_q.delete();
    for (int i = 0; i < len; i++) begin
      w = $urandom;
      exp_q.push_back(w & m);
      check("done early", 32'h1, {31'h0, done_oe});
      check("status load", 32'h0, {31'h0, status_oe});
      host.send_word(w, r);
    end
    if (status_oe === 1'b1) host.pulse_request();
    repeat (8) @(posedge pclk);
    check("done end", 32'h0, {31'h0, done_oe});
    check("init pin", 32'h1, {31'h0, init_done_oe});
    apb(1'b0, PCL_CNT_OFS, 32'h0);
    check("word count", 32'(exp_q.size()), rd);
    apb(1'b0, PCL_WORD_OFS, 32'h0);
    check("last word", exp_q[$], rd);
    host.clock_falls(2);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(85));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("por status", 32'h1, {31'h0, status_oe});
    check("por done", 32'h1, {31'h0, done_oe});
    check("init pin off", 32'h0, {31'h0, init_done_oe});
    check("od levels", 32'h0, {29'h0, status_out, done_out, init_done_out});
    apb(1'b0, PCL_CTRL_OFS, 32'h0);
    check("ctrl reset", {26'h0, PCL_CTRL_RST}, rd);
    apb(1'b0, PCL_LEN_OFS, 32'h0);
    check("len reset", PCL_LEN_RST, rd);
    apb(1'b1, 8'h1c, 32'hffff_ffff);
    check("unmapped err", 32'h1, {31'h0, se});
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped rd", 32'h0, rd);
    wait_status(n);
    check("por release", 32'h1, {31'h0, n < 100});
    $display("test reset done");
    for (int wd = 0; wd < 3; wd++) begin
      for (int f = 0; f < 4; f++) begin
        // init pin enabled so its hold-low is visible every pass
        do_load({2'b01, f[1], f[0], wd[1:0]}, 1 + $urandom_range(2));
        repeat (SHORT + 20) @(posedge pclk);
        apb(1'b0, PCL_STAT_OFS, 32'h0);
        check("user state", 32'h7, {29'h0, rd[2:0]});
        check("init pin user", 32'h0, {31'h0, init_done_oe});
        check("pins user", 32'h0, {30'h0, status_oe, done_oe});
        host.clock_falls(3);
        apb(1'b0, PCL_CNT_OFS, 32'h0);
        check("count frozen", 32'(exp_q.size()), rd);
        w = $urandom;
        apb(1'b1, PCL_UOUT_OFS, w);
        apb(1'b1, PCL_UOE_OFS, ~w);
        repeat (3) @(posedge pclk);
        check("user out", w, data_out);
        check("user oe", ~w, data_oe);
        $display("test load width %0d features %0d done", wd, f);
      end
    end
    // user clock init: fixed count, so only checked once (slow)
    do_load(6'h32, 1);
    repeat (PCL_USER_INIT_EDGES * 4 - 200) @(posedge pclk);
    apb(1'b0, PCL_STAT_OFS, 32'h0);
    check("user clk early", 32'h1, {31'h0, rd[2:0] != 3'h7});
    repeat (400) @(posedge pclk);
    apb(1'b0, PCL_STAT_OFS, 32'h0);
    check("user clk late", 32'h7, {29'h0, rd[2:0]});
    $display("test user clock init done");
    end_sim();
  end

  initial begin
    #2_400_000;
    err_total++;
    $display("ERROR watchdog expected finish seen timeout");
    end_sim();
  end
endmodule
`default_nettype wire
